// *** hw/scsi_seq_pkg.sv ***
// scsi_seq_pkg: shared constants, flag positions, command codes and
// carrier types of the selection and diagnostic sequencer.
// assumes a single 200 MHz device clock.
`default_nettype none

package scsi_seq_pkg;

  // clock and timing figures, times in their own unit
  localparam int clk_period_ns = 5;
  localparam int timeout_unit_us = 146;
  localparam int pause_hold_us = 100;
  localparam int timeout_unit_cycles =
    (timeout_unit_us * 1000 + clk_period_ns - 1) / clk_period_ns;
  // least time, so rounded up
  localparam int pause_hold_cycles =
    (pause_hold_us * 1000 + clk_period_ns - 1) / clk_period_ns;

  // command register codes
  localparam logic [7:0] cmd_chip_reset = 8'h00;
  localparam logic [7:0] cmd_disconnect = 8'h01;
  localparam logic [7:0] cmd_pause = 8'h02;
  localparam logic [7:0] cmd_chip_disable = 8'h05;
  localparam logic [7:0] cmd_select_atn = 8'h06;
  localparam logic [7:0] cmd_select_no_atn = 8'h07;
  localparam logic [7:0] cmd_reselect = 8'h08;
  localparam logic [7:0] cmd_turnaround = 8'h09;

  // interrupt cause register bit positions
  localparam int function_done_flag = 0;
  localparam int bus_service_flag = 1;
  localparam int disconnect_flag = 2;
  localparam int reselected_flag = 3;
  localparam int selected_flag = 4;
  localparam int bad_command_flag = 6;

  // auxiliary status register bit positions
  localparam int count_zero_flag = 1;
  localparam int paused_flag = 2;
  localparam int data_full_flag = 7;

  // self-test result field and its codes
  localparam int result_lo = 3;
  localparam int result_hi = 6;
  localparam logic [3:0] result_good_parity = 4'h0;
  localparam logic [3:0] result_bad_parity = 4'h1;
  localparam logic [3:0] result_miscompare_initial = 4'h2;
  localparam logic [3:0] result_miscompare_final = 4'h3;

  // values after reset
  localparam logic [7:0] byte_reset = 8'h00;
  localparam logic [2:0] id_reset = 3'h0;

  // lines the device may drive, and lines it senses
  typedef struct packed {
    logic bsy;
    logic sel;
    logic atn;
    logic io;
    logic [7:0] id;
  } scsi_drive_type;

  typedef struct packed {
    logic bsy;
    logic sel;
    logic atn;
    logic rst;
  } scsi_sense_type;

  function automatic logic [7:0] id_onehot(input logic [2:0] n);
    id_onehot = 8'h01 << n;
  endfunction

  function automatic logic odd_parity(input logic [7:0] b);
    odd_parity = ~^b;
  endfunction

endpackage

`default_nettype wire

// *** hw/response_timer.sv ***
// response_timer: transfer counter with a prescaled timeout unit.
// assumes run is high only in the selection phase and start pulses the
// cycle before run rises.
`default_nettype none

module response_timer #(
  parameter int tc_width = 16,
  parameter int unit_cycles = scsi_seq_pkg::timeout_unit_cycles
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clear,
  input wire logic load,
  input wire logic [tc_width-1:0] load_value,
  input wire logic run,
  input wire logic start,
  output logic expired,
  output logic count_zero,
  output logic [tc_width-1:0] count
);
  import scsi_seq_pkg::*;

  localparam int pw = $clog2(unit_cycles + 1);
  localparam logic [pw-1:0] pre_last = pw'(unit_cycles - 1);
  localparam logic [tc_width-1:0] count_one = tc_width'(1);

  logic [pw-1:0] pre;
  logic enabled;
  logic tick;

  assign tick = run && enabled && (pre == pre_last);
  assign count_zero = (count == '0);

  // prescaler restarts with each selection so the first unit is whole
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pre <= '0;
    end else if (clear || !run || pre == pre_last) begin
      pre <= '0;
    end else begin
      pre <= pre + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      enabled <= 1'b0;
    end else if (clear) begin
      enabled <= 1'b0;
    end else if (start) begin
      enabled <= !count_zero;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count <= '0;
    end else if (clear) begin
      count <= '0;
    end else if (load) begin
      count <= load_value;
    end else if (tick && !count_zero) begin
      count <= count - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      expired <= 1'b0;
    end else begin
      expired <= !clear && tick && (count == count_one);
    end
  end

endmodule // response_timer

`default_nettype wire

// *** hw/turnaround_unit.sv ***
// turnaround_unit: walks a byte through two internal registers and back.
// assumes src and src_par hold steady while busy.
`default_nettype none

module turnaround_unit (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clear,
  input wire logic start,
  input wire logic [7:0] src,
  input wire logic src_par,
  output logic done,
  output logic [3:0] code,
  output logic [7:0] data_back
);
  import scsi_seq_pkg::*;

  typedef enum logic [2:0] {
    t_idle, t_copy, t_check, t_parity, t_back, t_final
  } turn_state_type;

  turn_state_type state;
  logic [7:0] second;
  logic [7:0] third;
  logic bad_initial;
  logic bad_parity;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= t_idle;
      second <= byte_reset;
      third <= byte_reset;
      data_back <= byte_reset;
      bad_initial <= 1'b0;
      bad_parity <= 1'b0;
    end else if (clear) begin
      state <= t_idle;
    end else begin
      case (state)
        t_idle: begin
          if (start) begin
            state <= t_copy;
          end
        end
        t_copy: begin
          second <= src;
          state <= t_check;
        end
        t_check: begin
          bad_initial <= (second != src);
          third <= second;
          state <= t_parity;
        end
        t_parity: begin
          bad_parity <= (odd_parity(third) != src_par);
          state <= t_back;
        end
        t_back: begin
          data_back <= third;
          state <= t_final;
        end
        t_final: begin
          state <= t_idle;
        end
        default: state <= t_idle;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      done <= 1'b0;
      code <= result_good_parity;
    end else begin
      done <= !clear && state == t_final;
      if (!clear && state == t_final) begin
        // earlier faults mask later ones
        if (bad_initial) begin
          code <= result_miscompare_initial;
        end else if (bad_parity) begin
          code <= result_bad_parity;
        end else if (data_back != second) begin
          code <= result_miscompare_final;
        end else begin
          code <= result_good_parity;
        end
      end
    end
  end

endmodule // turnaround_unit

`default_nettype wire

// *** hw/scsi_select_diag_sequencer.sv ***
// scsi_select_diag_sequencer: chip disable, select, reselect, pause abort
// and data turnaround self-test of a SCSI protocol controller.
// assumes an outside arbiter reports a win and selection by others, and
// host strobes are one-cycle pulses synchronous to clk.
//
// Overview of operation
// - disable stops everything, releases all outputs
// - disabled ignores all but reset events
// - counter holds timeout in 146 us units
// - zero count waits forever for response
// - select with attention only when disconnected
// - being selected during arbitration aborts, interrupts
// - won arbitration: selection with attention, timer
// - no response in time: leave, disconnected
// - response in time sets function done
// - pause, disable or reset abort; interrupts beat paused
// - select without attention keeps attention low
// - reselect valid disconnected, same timeout handling
// - after reselect read, attention sets service
// - command racing service interrupt is ignored
// - turnaround command clears data full flag
// - byte walks through internal registers, compared
// - result code stored in the same cycle as function done
// - chip reset clears everything like reset
// - pause after win: hold select, check busy
`default_nettype none

module scsi_select_diag_sequencer #(
  parameter int tc_width = 16,
  parameter int unit_cycles = scsi_seq_pkg::timeout_unit_cycles,
  parameter int hold_cycles = scsi_seq_pkg::pause_hold_cycles
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic cmd_wr,
  input wire logic [7:0] cmd_in,
  input wire logic data_wr,
  input wire logic [7:0] data_in,
  input wire logic data_par_in,
  input wire logic data_rd,
  input wire logic tid_wr,
  input wire logic [2:0] tid_in,
  input wire logic tc_wr,
  input wire logic [tc_width-1:0] tc_in,
  input wire logic ir_rd,
  input wire logic [2:0] own_id,
  input wire logic arb_won,
  input wire logic sel_by_other,
  input wire logic sel_by_other_atn,
  input wire logic resel_by_other,
  input wire scsi_seq_pkg::scsi_sense_type scsi_in,
  output logic [7:0] interrupt_cause_register,
  output logic [7:0] auxiliary_status_register,
  output logic [7:0] self_test_result,
  output logic [7:0] data_holding_register,
  output logic [7:0] command_register,
  output logic [2:0] target_id_register,
  output logic arb_req,
  output scsi_seq_pkg::scsi_drive_type scsi_drv,
  output scsi_seq_pkg::scsi_drive_type scsi_en
);
  import scsi_seq_pkg::*;

  typedef enum logic [3:0] {
    st_disabled, st_idle, st_arbitrate, st_select, st_pause_hold,
    st_pause_check, st_initiator, st_wait_ir_read, st_target,
    st_diag_wait, st_diag_run
  } seq_state_type;

  localparam int hw = $clog2(hold_cycles + 1);
  localparam logic [hw-1:0] hold_last = hw'(hold_cycles - 1);

  seq_state_type state;
  seq_state_type next_state;
  logic soft_clear;
  logic [7:0] ir_set;
  logic paused_set;
  logic start_timer;
  logic diag_start;
  logic diag_done;
  logic [3:0] diag_code;
  logic [7:0] diag_back;
  logic timer_expired;
  logic count_zero;
  logic [hw-1:0] hold_cnt;
  logic hold_done;
  logic reselecting;
  logic with_atn;
  logic atn_prev;
  logic data_par;
  logic paused;
  logic data_full;
  logic is_connect_cmd;
  logic cmd_live;

  // chip reset or bus reset restart everything
  // reset events are the only way out of disable
  assign soft_clear = scsi_in.rst || (cmd_wr && cmd_in == cmd_chip_reset);
  assign cmd_live = cmd_wr && state != st_disabled;
  assign is_connect_cmd = cmd_in == cmd_select_atn ||
                          cmd_in == cmd_select_no_atn ||
                          cmd_in == cmd_reselect;
  assign hold_done = hold_cnt == hold_last;

  response_timer #(
    .tc_width(tc_width),
    .unit_cycles(unit_cycles)
  ) timer (
    .clk(clk),
    .arst_n(arst_n),
    .clear(soft_clear),
    .load(tc_wr && state != st_disabled),
    .load_value(tc_in),
    .run(state == st_select),
    .start(start_timer),
    .expired(timer_expired),
    .count_zero(count_zero),
    .count()
  );

  turnaround_unit turn (
    .clk(clk),
    .arst_n(arst_n),
    .clear(soft_clear),
    .start(diag_start),
    .src(data_holding_register),
    .src_par(data_par),
    .done(diag_done),
    .code(diag_code),
    .data_back(diag_back)
  );

  // sequencing decisions; interrupt events are raised before pause
  always_comb begin
    next_state = state;
    ir_set = 8'h00;
    paused_set = 1'b0;
    start_timer = 1'b0;
    diag_start = 1'b0;
    case (state)
      st_disabled: begin
        next_state = st_disabled;
      end
      st_idle: begin
        if (sel_by_other) begin
          ir_set[selected_flag] = 1'b1;
          ir_set[bus_service_flag] = sel_by_other_atn;
          next_state = st_target;
        end else if (resel_by_other) begin
          ir_set[reselected_flag] = 1'b1;
          next_state = st_initiator;
        end else if (cmd_live && is_connect_cmd) begin
          next_state = st_arbitrate;
        end else if (cmd_live && cmd_in == cmd_pause) begin
          paused_set = 1'b1;
        end else if (cmd_live && cmd_in == cmd_turnaround) begin
          next_state = st_diag_wait;
        end
      end
      st_arbitrate: begin
        if (sel_by_other) begin
          ir_set[selected_flag] = 1'b1;
          ir_set[bus_service_flag] = sel_by_other_atn;
          next_state = st_target;
        end else if (resel_by_other) begin
          ir_set[reselected_flag] = 1'b1;
          next_state = st_initiator;
        end else if (cmd_live && cmd_in == cmd_pause) begin
          paused_set = 1'b1;
          next_state = st_idle;
        end else if (arb_won) begin
          start_timer = 1'b1;
          next_state = st_select;
        end
      end
      st_select: begin
        if (scsi_in.bsy) begin
          ir_set[function_done_flag] = 1'b1;
          next_state = reselecting ? st_wait_ir_read : st_initiator;
        end else if (timer_expired) begin
          ir_set[disconnect_flag] = 1'b1;
          next_state = st_idle;
        end else if (cmd_live && cmd_in == cmd_pause) begin
          next_state = st_pause_hold;
        end
      end
      st_pause_hold: begin
        // late response still wins over pause
        if (scsi_in.bsy) begin
          ir_set[function_done_flag] = 1'b1;
          next_state = reselecting ? st_wait_ir_read : st_initiator;
        end else if (hold_done) begin
          next_state = st_pause_check;
        end
      end
      st_pause_check: begin
        if (!scsi_in.bsy) begin
          paused_set = 1'b1;
          next_state = st_idle;
        end else begin
          ir_set[function_done_flag] = 1'b1;
          next_state = reselecting ? st_wait_ir_read : st_initiator;
        end
      end
      st_initiator: begin
        if (cmd_live && cmd_in == cmd_disconnect) begin
          next_state = st_idle;
        end
      end
      st_wait_ir_read: begin
        if (ir_rd) begin
          next_state = st_target;
        end
      end
      st_target: begin
        if (scsi_in.atn && !atn_prev) begin
          ir_set[bus_service_flag] = 1'b1;
          next_state = st_wait_ir_read;
        end else if (cmd_live && cmd_in == cmd_disconnect) begin
          next_state = st_idle;
        end
      end
      st_diag_wait: begin
        if (data_wr) begin
          diag_start = 1'b1;
          next_state = st_diag_run;
        end
      end
      st_diag_run: begin
        if (diag_done) begin
          ir_set[function_done_flag] = 1'b1;
          next_state = st_idle;
        end
      end
      default: next_state = st_idle;
    endcase
    if (cmd_live && is_connect_cmd && state != st_idle &&
        state != st_wait_ir_read) begin
      ir_set[bad_command_flag] = 1'b1;
    end
    if (cmd_live && cmd_in == cmd_chip_disable) begin
      ir_set = 8'h00;
      paused_set = 1'b0;
      start_timer = 1'b0;
      diag_start = 1'b0;
      next_state = st_disabled;
    end
  end

  // state register; the reset events override everything
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= st_idle;
    end else if (soft_clear) begin
      state <= st_idle;
    end else begin
      state <= next_state;
    end
  end

  // role and attention choice latched with the command
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reselecting <= 1'b0;
      with_atn <= 1'b0;
      atn_prev <= 1'b0;
    end else if (soft_clear) begin
      reselecting <= 1'b0;
      with_atn <= 1'b0;
      atn_prev <= 1'b0;
    end else begin
      atn_prev <= scsi_in.atn;
      if (state == st_idle && next_state == st_arbitrate) begin
        reselecting <= cmd_in == cmd_reselect;
        with_atn <= cmd_in == cmd_select_atn;
      end
    end
  end

  // select hold time while ids are withdrawn
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hold_cnt <= '0;
    end else if (soft_clear || state != st_pause_hold) begin
      hold_cnt <= '0;
    end else if (!hold_done) begin
      hold_cnt <= hold_cnt + 1'b1;
    end
  end

  // interrupt causes: a read clears, but a new event in that cycle stays
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      interrupt_cause_register <= byte_reset;
    end else if (soft_clear) begin
      interrupt_cause_register <= byte_reset;
    end else if (ir_rd) begin
      interrupt_cause_register <= ir_set;
    end else begin
      interrupt_cause_register <= interrupt_cause_register | ir_set;
    end
  end

  // paused and data full flags, set wins over clear
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      paused <= 1'b0;
      data_full <= 1'b0;
    end else if (soft_clear) begin
      paused <= 1'b0;
      data_full <= 1'b0;
    end else begin
      if (paused_set) begin
        paused <= 1'b1;
      end else if (cmd_live && cmd_in != cmd_pause) begin
        paused <= 1'b0;
      end
      if (state == st_diag_run && diag_done) begin
        data_full <= 1'b1;
      end else if (data_rd ||
                   (cmd_live && cmd_in == cmd_turnaround)) begin
        data_full <= 1'b0;
      end
    end
  end

  // count zero is shown but is no timeout indication
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      auxiliary_status_register <= byte_reset;
    end else begin
      auxiliary_status_register <= byte_reset;
      auxiliary_status_register[data_full_flag] <= data_full;
      auxiliary_status_register[paused_flag] <= paused;
      auxiliary_status_register[count_zero_flag] <= count_zero;
    end
  end

  // host loaded registers and the turnaround result
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      command_register <= byte_reset;
      target_id_register <= id_reset;
      data_holding_register <= byte_reset;
      data_par <= 1'b0;
      self_test_result <= byte_reset;
    end else if (soft_clear) begin
      command_register <= byte_reset;
      target_id_register <= id_reset;
      data_holding_register <= byte_reset;
      data_par <= 1'b0;
      self_test_result <= byte_reset;
    end else begin
      if (cmd_live) begin
        command_register <= cmd_in;
      end
      if (tid_wr && state != st_disabled) begin
        target_id_register <= tid_in;
      end
      if (state == st_diag_run && diag_done) begin
        data_holding_register <= diag_back;
        self_test_result[result_hi:result_lo] <= diag_code;
      end else if (data_wr && state != st_disabled) begin
        data_holding_register <= data_in;
        data_par <= data_par_in;
      end
    end
  end

  // bus drive follows the coming state so pins change with it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      arb_req <= 1'b0;
      scsi_drv <= '0;
      scsi_en <= '0;
    end else begin
      arb_req <= 1'b0;
      scsi_drv <= '0;
      scsi_en <= '0;
      if (!soft_clear) begin
        case (next_state)
          st_arbitrate: begin
            arb_req <= 1'b1;
            scsi_drv.bsy <= 1'b1;
            scsi_drv.id <= id_onehot(own_id);
            scsi_en.bsy <= 1'b1;
            scsi_en.id <= 8'hFF;
          end
          st_select: begin
            scsi_drv.sel <= 1'b1;
            scsi_drv.atn <= with_atn;
            scsi_drv.io <= reselecting;
            scsi_drv.id <= id_onehot(own_id) |
                           id_onehot(target_id_register);
            scsi_en.sel <= 1'b1;
            scsi_en.atn <= 1'b1;
            scsi_en.io <= 1'b1;
            scsi_en.id <= 8'hFF;
          end
          st_pause_hold, st_pause_check: begin
            scsi_drv.sel <= 1'b1;
            scsi_en.sel <= 1'b1;
          end
          st_target, st_wait_ir_read: begin
            scsi_drv.bsy <= reselecting;
            scsi_drv.io <= reselecting;
            scsi_en.bsy <= reselecting;
            scsi_en.io <= reselecting;
          end
          default: begin
            arb_req <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule // scsi_select_diag_sequencer

`default_nettype wire

// *** sim/sel_props.sv ***
// sel_props: port-level checks of the sequencer.
// assumes binding onto the sequencer top; one clock.
`default_nettype none
module sel_props (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic cmd_wr,
  input wire logic [7:0] cmd_in,
  input wire logic [2:0] own_id,
  input wire logic arb_won,
  input wire scsi_seq_pkg::scsi_sense_type scsi_in,
  input wire logic [7:0] interrupt_cause_register,
  input wire logic [7:0] auxiliary_status_register,
  input wire logic [7:0] command_register,
  input wire logic [2:0] target_id_register,
  input wire logic arb_req,
  input wire scsi_seq_pkg::scsi_drive_type scsi_drv,
  input wire scsi_seq_pkg::scsi_drive_type scsi_en
);
  import scsi_seq_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // a command write; a selection start
  sequence s_cmd(logic [7:0] c);
    cmd_wr && cmd_in == c;
  endsequence
  sequence s_sel_start;
    $rose(scsi_en.sel);
  endsequence
  a_disable_drop: assert property (
    s_cmd(cmd_chip_disable) |=> scsi_en == '0 && !arb_req)
    else $error("driven after disable");
  a_disabled_deaf: assert property (
    s_cmd(cmd_chip_disable) ##1 s_cmd(cmd_select_atn) |=> !arb_req)
    else $error("select while disabled");
  a_busy_bad: assert property (
    arb_req && cmd_wr && cmd_in == cmd_select_atn
      |=> interrupt_cause_register[6])
    else $error("busy select accepted");
  a_win_select: assert property (
    arb_req && arb_won |=> scsi_en.sel && scsi_drv.sel)
    else $error("no select after win");
  a_atn_on: assert property (
    s_sel_start |-> command_register != cmd_select_atn
      || (scsi_en.atn && scsi_drv.atn))
    else $error("attention missing");
  a_atn_off: assert property (
    s_sel_start |-> command_register != cmd_select_no_atn
      || !(scsi_en.atn && scsi_drv.atn))
    else $error("attention unasked");
  a_target_id: assert property (
    s_sel_start |-> scsi_drv.id
      == ((8'h01 << own_id) | (8'h01 << target_id_register)))
    else $error("wrong ids");
  a_answer_done: assert property (
    scsi_en.sel && scsi_in.bsy |=> interrupt_cause_register[0])
    else $error("answer not done");
  a_turn_clear: assert property (
    s_cmd(cmd_turnaround) |-> ##3 !auxiliary_status_register[7])
    else $error("full not cleared");
  a_turn_done: assert property (
    $rose(auxiliary_status_register[7])
      && command_register == cmd_turnaround
      |-> interrupt_cause_register[0])
    else $error("turnaround not done");
  a_reset_clear: assert property (
    s_cmd(cmd_chip_reset) |=> interrupt_cause_register == 8'h00
      && scsi_en == '0 && !arb_req)
    else $error("reset left state");
endmodule // sel_props
bind scsi_select_diag_sequencer sel_props props (.*);
`default_nettype wire

// *** sim/scsi_peer.sv ***
// scsi_peer: far-side target answering a selection with busy.
// assumes respond stays high while an answer is wanted.
`default_nettype none
module scsi_peer #(
  parameter int delay = 3
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic respond,
  input wire scsi_seq_pkg::scsi_drive_type drv,
  input wire scsi_seq_pkg::scsi_drive_type en,
  output logic bsy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] waited;
  // busy stays up once given, as a target holds it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      waited <= 4'h0;
      bsy <= 1'b0;
    end else if (!respond) begin
      waited <= 4'h0;
      bsy <= 1'b0;
    end else if (en.sel && drv.sel) begin
      waited <= waited + 4'h1;
      bsy <= bsy || waited == 4'(delay);
    end
  end
endmodule // scsi_peer
`default_nettype wire

// *** sim/scsi_select_diag_sequencer_bench.sv ***
// bench: directed tests of every command but reselect.
// assumes the peer model and checker are compiled with it.
`default_nettype none
module scsi_select_diag_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import scsi_seq_pkg::*;
  logic clk = 1'b0, arst_n = 1'b0, cmd_wr = 1'b0, data_wr = 1'b0;
  logic data_rd = 1'b0, tid_wr = 1'b0, tc_wr = 1'b0, ir_rd = 1'b0;
  logic arb_won = 1'b0, sel_by_other = 1'b0, respond = 1'b0;
  logic data_par_in = 1'b0, peer_bsy;
  logic [7:0] cmd_in = 8'h00, data_in = 8'h00;
  logic [7:0] cause, aux, result, held_byte, cmd_seen;
  logic [2:0] tid_in = 3'h0, tid_seen;
  logic [15:0] tc_in = 16'h0000;
  logic arb_req;
  scsi_drive_type drv, en;
  scsi_sense_type sense;
  int fails = 0, total_checks = 0;
  assign sense = '{bsy: peer_bsy, sel: 1'b0, atn: 1'b0, rst: 1'b0};
  always #2.5 clk = ~clk;
  scsi_select_diag_sequencer #(.unit_cycles(4), .hold_cycles(3)) uut (
    .clk(clk), .arst_n(arst_n), .cmd_wr(cmd_wr), .cmd_in(cmd_in),
    .data_wr(data_wr), .data_in(data_in), .data_par_in(data_par_in),
    .data_rd(data_rd), .tid_wr(tid_wr), .tid_in(tid_in), .tc_wr(tc_wr),
    .tc_in(tc_in), .ir_rd(ir_rd), .own_id(3'h6), .arb_won(arb_won),
    .sel_by_other(sel_by_other), .sel_by_other_atn(sel_by_other),
    .resel_by_other(1'b0), .scsi_in(sense),
    .interrupt_cause_register(cause), .auxiliary_status_register(aux),
    .self_test_result(result), .data_holding_register(held_byte),
    .command_register(cmd_seen), .target_id_register(tid_seen),
    .arb_req(arb_req), .scsi_drv(drv), .scsi_en(en));
  scsi_peer #(.delay(3)) peer (.clk(clk), .arst_n(arst_n),
    .respond(respond), .drv(drv), .en(en), .bsy(peer_bsy));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic gap(input int n);
    repeat (n) @(negedge clk);
  endtask
  // strobe kind k: cmd, data, target id, count, cause read, data read
  task automatic host(input int k, input logic [15:0] v);
    @(posedge clk);
    {cmd_wr, data_wr, tid_wr, tc_wr, ir_rd, data_rd} <= 6'b100000 >> k;
    {cmd_in, data_in, tid_in, tc_in} <= {v[7:0], v[7:0], v[2:0], v};
    data_par_in <= v[8];
    @(posedge clk);
    {cmd_wr, data_wr, tid_wr, tc_wr, ir_rd, data_rd} <= 6'h00;
  endtask
  task automatic sel(input logic [7:0] c, input int id, input int n);
    host(2, 16'(id));
    host(3, 16'(n));
    host(0, {8'h00, c});
  endtask
  // bounded wait on a cause bit
  task automatic wait_cause(input int b);
    for (int i = 0; i < 300 && cause[b] !== 1'b1; i++) @(negedge clk);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #20000;
    fails++;
    close_out();
  end
  initial begin
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    gap(1);
    chk(cause, 8'h00);
    chk(aux, 8'h00);
    arb_won <= 1'b1;
    respond <= 1'b1;
    sel(cmd_select_atn, 5, 2);
    wait_cause(0);
    chk(cause, 8'h01);
    chk(tid_seen, 3'h5);
    host(4, 0);
    host(0, cmd_disconnect);
    respond <= 1'b0;
    $display("test select done");
    // silent peer: two units of four cycles, then disconnected
    sel(cmd_select_no_atn, 2, 2);
    gap(5);
    chk(cause, 8'h00);
    wait_cause(2);
    chk(cause, 8'h04);
    chk(en, 12'h000);
    host(4, 0);
    $display("test timeout done");
    // zero count never expires; pause ends it
    sel(cmd_select_atn, 4, 0);
    gap(60);
    chk(cause, 8'h00);
    host(0, cmd_pause);
    gap(12);
    chk(aux[2], 1'b1);
    chk(en, 12'h000);
    chk(cause, 8'h00);
    $display("test pause done");
    // arbitration never won: refusal, then selection aborts it
    arb_won <= 1'b0;
    sel(cmd_select_no_atn, 1, 0);
    host(0, cmd_select_atn);
    sel_by_other <= 1'b1;
    wait_cause(4);
    gap(2);
    chk(cause, 8'h52);
    sel_by_other <= 1'b0;
    host(0, cmd_chip_reset);
    gap(3);
    chk(cause, 8'h00);
    $display("test abort done");
    // bad parity first, then good; 8'hA5 needs parity 1 to be odd
    for (int p = 0; p < 2; p++) begin
      host(0, cmd_turnaround);
      gap(3);
      chk(aux[7], 1'b0);
      host(1, {7'h00, p[0], 8'hA5});
      wait_cause(0);
      gap(3);
      chk(result[6:3], p ? result_good_parity : result_bad_parity);
      chk(aux[7], 1'b1);
      chk(held_byte, 8'hA5);
      host(4, 0);
    end
    host(5, 0);
    gap(3);
    chk(aux[7], 1'b0);
    $display("test turnaround done");
    arb_won <= 1'b1;
    host(0, cmd_chip_disable);
    sel(cmd_select_atn, 3, 0);
    gap(10);
    chk(en, 12'h000);
    chk(cause, 8'h00);
    host(0, cmd_chip_reset);
    host(0, cmd_pause);
    gap(4);
    chk(aux[2], 1'b1);
    $display("test disable done");
    close_out();
  end
endmodule // scsi_select_diag_sequencer_bench
`default_nettype wire
